// ===== bldq_map.svh
// Purpose: register offsets, field positions and reset values for the bulk list and done queue pointers
// Assumes: register byte offsets; the link offset is from the descriptor start address
// Notes:   definitions only
`ifndef BLDQ_MAP_SVH
`define BLDQ_MAP_SVH
`define BLDQ_BULK_CUR_OFS   8'h2c
`define BLDQ_DONE_HEAD_OFS  8'h30
`define BLDQ_LINK_OFS       32'h0000000c
`define BLDQ_ADDR_MSB       31
`define BLDQ_ADDR_LSB       4
`define BLDQ_PTR_RESET      28'h0000000
`define BLDQ_LIST_FILL_BIT  1
`define BLDQ_BULK_EN_BIT    5
`endif

// ===== bldq_mem_model.sv
// Purpose: memory side taking descriptor link and shared-area head writes
// Assumes: one write at a time  Notes: lat_i of 0 answers promptly
`timescale 1ns/1ps
module bldq_mem_model (
   input  wire logic       mclk_i,    // core clock
   input  wire logic       sys_rst_i, // reset
   input  wire logic       mem_wr_i,  // write request
   input  wire logic [3:0] lat_i,     // accept delay
   output      logic       mem_ack_o  // write accepted
);
   logic [3:0] wait_cnt;
   always_ff @(posedge mclk_i) begin
      wait_cnt  <= (sys_rst_i || !mem_wr_i || mem_ack_o) ? 4'h0 : wait_cnt + 4'h1;
      mem_ack_o <= !sys_rst_i && mem_wr_i && !mem_ack_o && wait_cnt == lat_i;
   end
endmodule

// ===== bldq_pkg.sv
// Purpose: types for the bulk list and done queue pointer block
// Assumes: nothing
// Notes:   offsets live in bldq_map.svh
package bldq_pkg;
   typedef enum logic [1:0] {
      BLDQ_IDLE = 2'b00,
      BLDQ_LINK = 2'b01,
      BLDQ_SWAP = 2'b10
   } bldq_state_type;

   typedef struct packed {
      logic [27:0]    bulk_cur;
      logic [27:0]    done_head;
      logic [27:0]    td_addr;
      logic           flag_clear;
      logic [31:0]    rdata;
      logic           mem_wr;
      logic [31:0]    mem_addr;
      logic [31:0]    mem_data;
      bldq_state_type state;
   } bldq_regs_type;
endpackage

// ===== bldq_pointers.sv
// Purpose: bulk current descriptor pointer and completed queue head
// Assumes: the list walker and frame logic live elsewhere and drive the event inputs
// Notes:   register accesses are single-cycle strobes; read data is registered
// Notes on behaviour
// - bulk pointer holds address bits 31..4
// - bulk descriptors served round-robin, insertion order
// - advance pointer after serving descriptor
// - new frame resumes where bulk stopped
// - list end: if filled, reload head, clear
// - enabled reads return instantaneous pointer value
// - bulk pointer resets to zero, zero ends
// - queue head holds last completed descriptor
// - completed descriptor link gets old head
// - then head takes completed descriptor address
// - head copied periodically to shared area
// - copying head to shared area clears it
// - traversal begins at bulk head pointer
`timescale 1ns/1ps
`include "bldq_map.svh"
module bldq_pointers (
   input  wire logic        mclk_i,           // core clock
   input  wire logic        sys_rst_i,        // synchronous reset, high
   input  wire logic        reg_wr_i,         // register write strobe
   input  wire logic        reg_rd_i,         // register read strobe
   input  wire logic [7:0]  reg_addr_i,       // register byte offset
   input  wire logic [31:0] reg_wdata_i,      // register write data
   output      logic [31:0] reg_rdata_o,      // registered read data
   input  wire logic        bulk_list_enable_i, // control register bulk enable
   input  wire logic        list_filled_flag_i, // command status list filled flag
   output      logic        list_filled_clear_o, // pulse: clear list filled flag
   input  wire logic [27:0] bulk_list_head_pointer_i, // bulk head address field
   input  wire logic        bulk_served_i,    // pulse: current descriptor served
   input  wire logic [27:0] bulk_next_i,      // next link of served descriptor
   output      logic [27:0] bulk_current_address_field_o, // descriptor to serve
   output      logic        bulk_at_end_o,    // pointer is zero
   input  wire logic        td_done_i,        // pulse: descriptor completed
   input  wire logic [27:0] td_addr_i,        // completed descriptor address
   output      logic        td_ready_o,       // linker can take a completion
   input  wire logic        head_flush_i,     // pulse: write head to shared area
   input  wire logic [31:0] shared_head_addr_i, // shared area head word address
   output      logic        mem_wr_o,         // memory write request
   output      logic [31:0] mem_addr_o,       // memory write address
   output      logic [31:0] mem_data_o,       // memory write data
   input  wire logic        mem_ack_i         // memory write accepted
);
   bldq_pkg::bldq_regs_type cur_reg;
   bldq_pkg::bldq_regs_type cur_next;
   logic                    sw_bulk_wr;
   logic                    sw_done_wr;
   logic                    idle;

   // other side writes the bulk pointer only when disabled; while enabled those writes are dropped
   assign sw_bulk_wr = reg_wr_i && reg_addr_i == `BLDQ_BULK_CUR_OFS && !bulk_list_enable_i;
   assign sw_done_wr = reg_wr_i && reg_addr_i == `BLDQ_DONE_HEAD_OFS;
   assign idle       = cur_reg.state == bldq_pkg::BLDQ_IDLE && !cur_reg.mem_wr;

   always_comb begin
      cur_next            = cur_reg;
      cur_next.flag_clear = 1'b0;
      if (cur_reg.mem_wr && mem_ack_i) begin
         cur_next.mem_wr = 1'b0;
      end
      // written value is where bulk service resumes
      if (sw_bulk_wr) begin
         // reserved low bits are not stored
         cur_next.bulk_cur = reg_wdata_i[`BLDQ_ADDR_MSB:`BLDQ_ADDR_LSB];
      end else if (bulk_list_enable_i && bulk_served_i) begin
         cur_next.bulk_cur = bulk_next_i;
      end else if (bulk_list_enable_i && cur_reg.bulk_cur == `BLDQ_PTR_RESET && list_filled_flag_i
                   && !cur_reg.flag_clear) begin
         // wrap to head and clear the flag
         cur_next.bulk_cur   = bulk_list_head_pointer_i;
         cur_next.flag_clear = 1'b1;
      end
      if (sw_done_wr) begin
         cur_next.done_head = reg_wdata_i[`BLDQ_ADDR_MSB:`BLDQ_ADDR_LSB];
      end
      case (cur_reg.state)
         bldq_pkg::BLDQ_IDLE: begin
            if (idle && td_done_i) begin
               // link old head into the descriptor
               cur_next.td_addr  = td_addr_i;
               cur_next.mem_wr   = 1'b1;
               // next link word sits at a fixed offset inside the descriptor
               cur_next.mem_addr = {td_addr_i, 4'h0} + `BLDQ_LINK_OFS;
               cur_next.mem_data = {cur_reg.done_head, 4'h0};
               cur_next.state    = bldq_pkg::BLDQ_LINK;
            end else if (idle && head_flush_i) begin
               // copy head out, then clear it
               cur_next.mem_wr    = 1'b1;
               cur_next.mem_addr  = shared_head_addr_i;
               cur_next.mem_data  = {cur_reg.done_head, 4'h0};
               cur_next.done_head = `BLDQ_PTR_RESET;
            end
         end
         bldq_pkg::BLDQ_LINK: begin
            if (!cur_reg.mem_wr || mem_ack_i) begin
               cur_next.state = bldq_pkg::BLDQ_SWAP;
            end
         end
         bldq_pkg::BLDQ_SWAP: begin
            cur_next.done_head = cur_reg.td_addr;
            cur_next.state     = bldq_pkg::BLDQ_IDLE;
         end
         default: begin
            cur_next.state = bldq_pkg::BLDQ_IDLE;
         end
      endcase
      cur_next.rdata = 32'h00000000;
      if (reg_rd_i && reg_addr_i == `BLDQ_BULK_CUR_OFS) begin
         cur_next.rdata = {cur_reg.bulk_cur, 4'h0};
      end else if (reg_rd_i && reg_addr_i == `BLDQ_DONE_HEAD_OFS) begin
         cur_next.rdata = {cur_reg.done_head, 4'h0};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // pointer is never reloaded at frame start
   assign bulk_current_address_field_o = cur_reg.bulk_cur;
   assign bulk_at_end_o                = cur_reg.bulk_cur == `BLDQ_PTR_RESET;
   assign list_filled_clear_o          = cur_reg.flag_clear;
   assign reg_rdata_o                  = cur_reg.rdata;
   assign mem_wr_o                     = cur_reg.mem_wr;
   assign mem_addr_o                   = cur_reg.mem_addr;
   assign mem_data_o                   = cur_reg.mem_data;
   assign td_ready_o                   = idle;
endmodule

// ===== bldq_pointers_props.sv
// Purpose: concurrent checks on the bulk pointer and completed queue head
// Assumes: hand-over timing  Notes: ports grouped per line to stay compact
`timescale 1ns/1ps
module bldq_props (
   input wire logic        mclk_i, sys_rst_i, reg_wr_i, bulk_list_enable_i, list_filled_flag_i, bulk_served_i,
   input wire logic        list_filled_clear_o, bulk_at_end_o, td_done_i, td_ready_o, head_flush_i, mem_wr_o, mem_ack_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [27:0] bulk_list_head_pointer_i, bulk_next_i, bulk_current_address_field_o, td_addr_i,
   input wire logic [31:0] shared_head_addr_i, mem_addr_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   wire [27:0] ptr = bulk_current_address_field_o;
   // a clear pulse cycle is excluded: the wrap must not repeat there
   wire at_end = bulk_list_enable_i && ptr == '0 && !bulk_served_i && !reg_wr_i && !list_filled_clear_o;
   a_wrap_reload: assert property (at_end && list_filled_flag_i |=>
      ptr == $past(bulk_list_head_pointer_i) && list_filled_clear_o) else $error("no reload");
   a_idle_end: assert property (at_end && !list_filled_flag_i |=> ptr == '0 && !list_filled_clear_o) else $error("moved");
   a_serve_next: assert property (bulk_served_i && bulk_list_enable_i && !reg_wr_i |=>
      ptr == $past(bulk_next_i)) else $error("no advance");
   a_write_drop: assert property (reg_wr_i && reg_addr_i == 8'h2c && bulk_list_enable_i && !bulk_served_i &&
      ptr != '0 |=> $stable(ptr)) else $error("write taken");
   a_end_flag: assert property (bulk_at_end_o == (ptr == '0)) else $error("end flag");
   a_clear_single: assert property (list_filled_clear_o |=> !list_filled_clear_o) else $error("clear twice");
   a_link_write: assert property (td_done_i && td_ready_o |=>
      mem_wr_o && !td_ready_o && mem_addr_o == {$past(td_addr_i), 4'h0} + 32'hc) else $error("link addr");
   a_flush_write: assert property (head_flush_i && td_ready_o && !td_done_i |=>
      mem_wr_o && mem_addr_o == $past(shared_head_addr_i)) else $error("flush addr");
   a_write_held: assert property (mem_wr_o && !mem_ack_i |=> mem_wr_o && $stable(mem_addr_o)) else $error("dropped");
   c_wrap: cover property (list_filled_clear_o);
   c_link: cover property (td_done_i && td_ready_o);
   c_flush: cover property (head_flush_i && td_ready_o);
endmodule
bind bldq_pointers bldq_props props (.*);

// ===== bldq_pointers_test.sv
// Purpose: directed test of bulk pointer and completed queue head
// Assumes: inputs move on the falling edge
// Notes:   each access takes two cycles so strobes never toggle twice in one step
`timescale 1ns/1ps
module bldq_pointers_test;
   logic        mclk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, bulk_list_enable_i = 0, list_filled_flag_i = 0;
   logic        bulk_served_i = 0, td_done_i = 0, head_flush_i = 0, list_filled_clear_o, bulk_at_end_o, td_ready_o;
   logic        mem_wr_o, mem_ack_i;
   logic [7:0]  reg_addr_i = 0;
   logic [27:0] bulk_list_head_pointer_i = 28'h0000ab0, bulk_next_i = 0, td_addr_i = 0, bulk_current_address_field_o;
   logic [31:0] reg_wdata_i = 0, shared_head_addr_i = 32'h0000_0184, reg_rdata_o, mem_addr_o, mem_data_o, got;
   logic [3:0]  lat = 4'h3;
   int          error_cnt = 0, n_tests = 0;
   bldq_pointers dut (.*);
   bldq_mem_model mem (.mclk_i, .sys_rst_i, .mem_wr_i(mem_wr_o), .lat_i(lat), .mem_ack_o(mem_ack_i));
   initial forever #2.5 mclk_i = ~mclk_i;
   task automatic tick(int n); repeat (n) @(negedge mclk_i); endtask
   task automatic chk(logic [31:0] a, b); n_tests++; if (a !== b) begin error_cnt++; $display("BAD %0t %h %h", $time, a, b); end endtask
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d); {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, d};
      tick(1); got = reg_rdata_o; {reg_wr_i, reg_rd_i} = '0; tick(1); endtask
   task automatic pulse_td(logic [27:0] a); td_addr_i = a; td_done_i = 1; tick(1); td_done_i = 0; endtask
   task automatic mwait(logic [31:0] ea, ed); for (int i = 0; i < 30 && !(mem_wr_o && mem_ack_i); i++) tick(1);
      chk(mem_addr_o, ea); chk(mem_data_o, ed); for (int i = 0; i < 30 && !td_ready_o; i++) tick(1); endtask
   task automatic t_bulk;
      acc(0, 8'h2c, 0); chk(got, 0); chk(bulk_at_end_o, 1);
      acc(1, 8'h2c, 32'h1234_5670); chk(bulk_current_address_field_o, 28'h1234567);
      bulk_list_enable_i = 1;
      acc(1, 8'h2c, 32'h0000_0990); acc(0, 8'h2c, 0); chk(got, 32'h1234_5670);
      bulk_served_i = 1; tick(1); bulk_served_i = 0; chk(bulk_at_end_o, 1);
      tick(2); chk(bulk_current_address_field_o, 0);
      list_filled_flag_i = 1; tick(1); list_filled_flag_i = 0;
      chk(bulk_current_address_field_o, 28'h0000ab0); chk(list_filled_clear_o, 1);
   endtask
   task automatic t_done;
      acc(0, 8'h30, 0); chk(got, 0); acc(1, 8'h30, 32'h0000_0550);
      pulse_td(28'h00a0b0c); mwait(32'h00a0_b0cc, 32'h0000_0550);
      acc(0, 8'h30, 0); chk(got, 32'h00a0_b0c0); lat = 4'h0;
      pulse_td(28'h0000d0e); mwait(32'h0000_d0ec, 32'h00a0_b0c0);
      head_flush_i = 1; tick(1); head_flush_i = 0; mwait(32'h0000_0184, 32'h0000_d0e0);
      acc(0, 8'h30, 0); chk(got, 0); acc(0, 8'h3c, 0); chk(got, 0);
   endtask
   task automatic test_done; if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed"); $finish; endtask
   initial begin tick(5); sys_rst_i = 0; t_bulk(); t_done(); test_done(); end
   initial begin tick(2000); error_cnt++; test_done(); end
endmodule
